// file: logic/pbm_port_b_match.sv
// How it works
// RULE_01: Port B runs long, word or byte wide, picked by two select pins.
// RULE_02: Far side keeps width and bus-match selects steady during operation.
// RULE_03: Width takes effect at master reset end, before input ready rises.
// RULE_04: Endian select sampled when both master resets release, kept until next.
// RULE_05: Endian select has no effect in long-word mode.
// RULE_06: Big-endian moves most significant piece first, little-endian least first.
// RULE_07: Queue RAMs only see whole long words; conversion sits outside them.
// RULE_08: Mailbox transfers skip staging and reordering entirely.
// RULE_09: Mailbox uses low 18 lanes in word mode, low 9 in byte mode.
// RULE_10: Long-word mode moves the fetched word straight to the output register.
// RULE_11: Narrow reads show first piece, keep rest staged, step per read.
// RULE_12: Unused output lanes during narrow reads carry no defined data.
// RULE_13: Narrow writes stage pieces; the last piece commits the long word.
// RULE_14: Unused input lanes during narrow writes are ignored.
// RULE_15: Long-word mode maps port B lanes straight onto port A lanes.
// RULE_16: Word writes use B17-B0, big-endian upper half first.
// RULE_17: Byte writes use B8-B0, big-endian from the top byte down.
// RULE_18: Far side asserts both master resets together, partial reset held high.
// RULE_19: Far side keeps master reset high during a partial reset.
// RULE_20: Queue writes ignored until both input ready flags have risen.
// RULE_21: Word reads give upper half first big-endian, lower first little-endian.
// RULE_22: Byte reads use B8-B0, big-endian from the top byte.
// RULE_23: Any queue reset clears its staging, next transfer starts a new word.
`timescale 1ns/100ps
`default_nettype none
module pbm_port_b_match (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Configuration pins
  input  wire logic         bus_match_select,
  input  wire logic         size_select,
  input  wire logic         endian_select,
  input  wire logic         queue_ab_master_reset_n,
  input  wire logic         queue_ba_master_reset_n,
  input  wire logic         queue_ab_partial_reset_n,
  input  wire logic         queue_ba_partial_reset_n,
  input  wire logic         port_a_input_ready_flag,
  // A-to-B queue RAM read side
  input  wire logic [35:0]  abWord,
  input  wire logic         abValid,
  output logic              abPop,
  // B-to-A queue RAM write side
  input  wire logic         baFull,
  output logic [35:0]       baWord_r,
  output logic              baPush_r,
  // Port B transfers
  input  wire logic         pbRead,
  input  wire logic         pbWrite,
  input  wire logic         mbSelect,
  input  wire logic [35:0]  pbWrData,
  output logic [35:0]       pbRdData_r,
  output logic              port_b_output_ready_flag,
  output logic              port_b_input_ready_flag,
  // Mailbox bypass
  input  wire logic [35:0]  mail1Data,
  output logic [35:0]       pbMailData_r,
  output logic [35:0]       mail2Data_r,
  output logic              mail2Write_r,
  // Wishbone slave
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic         wb_we_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_cyc_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Index of the last piece of a long word for a width
  function automatic logic [1:0] lastPiece(input pbm_pkg::pbm_width_e w);
    case (w)
      pbm_pkg::PBM_WORD: lastPiece = 2'h1;
      pbm_pkg::PBM_BYTE: lastPiece = 2'h3;
      default:           lastPiece = 2'h0;
    endcase
  endfunction

  // Bit offset of piece k inside the long word
  function automatic logic [5:0] pieceShift(input pbm_pkg::pbm_cfg_s c, input logic [1:0] k);
    logic [5:0] s;
    s = 6'h00;
    case (c.width)
      pbm_pkg::PBM_WORD: s = c.bigEndian ? ((k == 2'h0) ? 6'h12 : 6'h00)  // RULE_16 RULE_21
                                         : ((k == 2'h0) ? 6'h00 : 6'h12);
      pbm_pkg::PBM_BYTE: s = c.bigEndian ? 6'(6'h1B - 6'(k) * 6'h09)     // RULE_17 RULE_22
                                         : 6'(6'(k) * 6'h09);
      default:           s = 6'h00;                                     // RULE_05 RULE_15
    endcase
    pieceShift = s;                                                     // RULE_06
  endfunction

  // Lanes that belong to the selected bus size
  function automatic logic [35:0] laneMask(input pbm_pkg::pbm_width_e w);
    case (w)
      pbm_pkg::PBM_WORD: laneMask = 36'h00003FFFF;
      pbm_pkg::PBM_BYTE: laneMask = 36'h0000001FF;
      default:           laneMask = 36'hFFFFFFFFF;
    endcase
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  pbm_pkg::pbm_cfg_s cfg_r;
  logic              cfgReady_r;
  logic              mrsActive;
  logic              mrsActive_r;
  logic [1:0]        ctrl_r;
  logic [35:0]       hold_r;
  logic [1:0]        rdPhase_r;
  logic              outValid_r;
  logic [35:0]       asm_r;
  logic [1:0]        wrPhase_r;
  logic              abClear;
  logic              baClear;
  logic              fetch;
  logic              rdTake;
  logic              wrTake;
  logic [1:0]        last;
  logic [35:0]       wrPlaced;
  logic [35:0]       fetchPiece;
  logic [35:0]       nextPiece;
  logic              wbHit;
  logic [31:0]       status;

  // ==========================================================
  // Configuration capture
  // ==========================================================
  assign mrsActive = !queue_ab_master_reset_n || !queue_ba_master_reset_n;

  // Release seen by comparing with last cycle; the flop resets to active, so leaving reset counts as a release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mrsActive_r <= 1'b1;
    else
      mrsActive_r <= mrsActive;
  end

  // Width and endian latched on the release edge, then held until the next
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_r      <= pbm_pkg::CFG_RESET;
      cfgReady_r <= 1'b0;
    end
    else if (mrsActive)
      cfgReady_r <= 1'b0;
    else if (mrsActive_r)
    begin
      cfg_r.width     <= !bus_match_select ? pbm_pkg::PBM_LONG   // RULE_01
                       : (size_select ? pbm_pkg::PBM_BYTE : pbm_pkg::PBM_WORD);
      cfg_r.bigEndian <= endian_select;                          // RULE_04
      cfgReady_r      <= 1'b1;                                   // RULE_03
    end
  end

  assign last = lastPiece(cfg_r.width);

  // ==========================================================
  // Read path from the A-to-B queue
  // ==========================================================
  assign abClear = mrsActive || !queue_ab_partial_reset_n;
  assign rdTake  = pbRead && !mbSelect && outValid_r;       // RULE_08
  // Fetch only when the output register is free or its last piece leaves
  assign fetch   = abValid && cfgReady_r && !ctrl_r[pbm_pkg::CTRL_READ_HOLD] && !abClear
                && (!outValid_r || (rdTake && rdPhase_r == last));
  assign abPop   = fetch;                                   // RULE_07

  assign fetchPiece = (abWord >> pieceShift(cfg_r, 2'h0)) & laneMask(cfg_r.width);
  assign nextPiece  = (hold_r >> pieceShift(cfg_r, 2'(rdPhase_r + 2'h1)))
                    & laneMask(cfg_r.width);

  // Output register and staging; unused lanes are driven low
  always_ff @(posedge clk)
  begin
    if (!rst_n || abClear)
    begin
      hold_r     <= 36'h000000000;                         // RULE_23
      rdPhase_r  <= 2'h0;
      outValid_r <= 1'b0;
      pbRdData_r <= 36'h000000000;
    end
    else if (fetch)
    begin
      hold_r     <= abWord;                                // RULE_11
      rdPhase_r  <= 2'h0;
      outValid_r <= 1'b1;
      pbRdData_r <= fetchPiece;                            // RULE_10 RULE_12
    end
    else if (rdTake)
    begin
      if (rdPhase_r == last)
        outValid_r <= 1'b0;
      else
      begin
        rdPhase_r  <= 2'(rdPhase_r + 2'h1);
        pbRdData_r <= nextPiece;                           // RULE_11 RULE_22
      end
    end
  end

  assign port_b_output_ready_flag = outValid_r;

  // ==========================================================
  // Write path to the B-to-A queue
  // ==========================================================
  assign baClear = mrsActive || !queue_ba_partial_reset_n;
  assign port_b_input_ready_flag = cfgReady_r && !baFull && !baClear
                                && !ctrl_r[pbm_pkg::CTRL_WRITE_HOLD];
  assign wrTake  = pbWrite && !mbSelect && port_b_input_ready_flag
                && port_a_input_ready_flag;                // RULE_20 RULE_08
  assign wrPlaced = (pbWrData & laneMask(cfg_r.width))      // RULE_14
                 << pieceShift(cfg_r, wrPhase_r);

  // Pieces gather in the staging word; the last one commits the whole word
  always_ff @(posedge clk)
  begin
    if (!rst_n || baClear)
    begin
      asm_r     <= 36'h000000000;                          // RULE_23
      wrPhase_r <= 2'h0;
      baWord_r  <= 36'h000000000;
      baPush_r  <= 1'b0;
    end
    else if (wrTake && wrPhase_r == last)
    begin
      baWord_r  <= asm_r | wrPlaced;                       // RULE_13 RULE_15 RULE_07
      baPush_r  <= 1'b1;
      asm_r     <= 36'h000000000;
      wrPhase_r <= 2'h0;
    end
    else if (wrTake)
    begin
      asm_r     <= asm_r | wrPlaced;                       // RULE_13 RULE_16 RULE_17
      wrPhase_r <= 2'(wrPhase_r + 2'h1);
      baPush_r  <= 1'b0;
    end
    else
      baPush_r  <= 1'b0;
  end

  // ==========================================================
  // Mailbox bypass
  // ==========================================================
  // Lanes outside the bus size read low rather than floating
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pbMailData_r <= 36'h000000000;
      mail2Data_r  <= 36'h000000000;
      mail2Write_r <= 1'b0;
    end
    else
    begin
      pbMailData_r <= mail1Data & laneMask(cfg_r.width);   // RULE_09
      mail2Write_r <= pbWrite && mbSelect;
      if (pbWrite && mbSelect)
        mail2Data_r <= pbWrData & laneMask(cfg_r.width);   // RULE_09 RULE_08
    end
  end

  // ==========================================================
  // Wishbone register file
  // ==========================================================
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Status word shows live mode and staging position
  always_comb
  begin
    status = 32'h00000000;
    status[pbm_pkg::ST_WIDTH +: 2] = cfg_r.width;
    status[pbm_pkg::ST_ENDIAN]  = cfg_r.bigEndian;
    status[pbm_pkg::ST_CFG_RDY] = cfgReady_r;
    status[pbm_pkg::ST_OUT_RDY] = outValid_r;
    status[pbm_pkg::ST_IN_RDY]  = port_b_input_ready_flag;
    status[pbm_pkg::ST_RD_PH +: 2] = rdPhase_r;
    status[pbm_pkg::ST_WR_PH +: 2] = wrPhase_r;
  end

  // One-cycle answer; unmapped addresses ack and read zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r   <= pbm_pkg::CTRL_RESET;
    end
    else
    begin
      wb_ack_o <= wbHit;
      wb_dat_o <= 32'h00000000;
      if (wbHit && wb_we_i)
      begin
        if (wb_adr_i == pbm_pkg::ADDR_CTRL && wb_sel_i[0])
          ctrl_r <= wb_dat_i[1:0];
      end
      else if (wbHit)
      begin
        if (wb_adr_i == pbm_pkg::ADDR_CTRL)
          wb_dat_o <= {30'h00000000, ctrl_r};
        else if (wb_adr_i == pbm_pkg::ADDR_STATUS)
          wb_dat_o <= status;
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/pbm_pkg.sv
`default_nettype none
package pbm_pkg;

  // ==========================================================
  // Widths and lane counts
  // ==========================================================
  localparam int unsigned LONG_W  = 36;
  localparam int unsigned WORD_W  = 18;
  localparam int unsigned BYTE_W  = 9;
  localparam int unsigned PHASE_W = 2;

  // ==========================================================
  // Port B bus size modes
  // ==========================================================
  typedef enum logic [1:0] {
    PBM_LONG = 2'h0,
    PBM_WORD = 2'h1,
    PBM_BYTE = 2'h3
  } pbm_width_e;

  // Configuration captured at master reset release
  typedef struct packed {
    pbm_width_e width;
    logic       bigEndian;
  } pbm_cfg_s;

  localparam pbm_cfg_s CFG_RESET = '{width: PBM_LONG, bigEndian: 1'b1};

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control fields
  localparam int unsigned CTRL_READ_HOLD  = 0;
  localparam int unsigned CTRL_WRITE_HOLD = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // Status fields
  localparam int unsigned ST_WIDTH   = 0;
  localparam int unsigned ST_ENDIAN  = 2;
  localparam int unsigned ST_CFG_RDY = 3;
  localparam int unsigned ST_OUT_RDY = 4;
  localparam int unsigned ST_IN_RDY  = 5;
  localparam int unsigned ST_RD_PH   = 8;
  localparam int unsigned ST_WR_PH   = 12;

endpackage
`default_nettype wire

// file: test/pbm_port_b_match_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pbm_port_b_match_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Configuration pins
  input wire logic        bus_match_select,
  input wire logic        size_select,
  input wire logic        queue_ab_master_reset_n,
  input wire logic        queue_ba_master_reset_n,
  input wire logic        port_a_input_ready_flag,
  // Queue RAM sides
  input wire logic [35:0] abWord,
  input wire logic        abPop,
  input wire logic [35:0] baWord_r,
  input wire logic        baPush_r,
  // Port B transfers
  input wire logic        pbWrite,
  input wire logic        mbSelect,
  input wire logic [35:0] pbWrData,
  input wire logic [35:0] pbRdData_r,
  input wire logic        port_b_output_ready_flag,
  input wire logic        port_b_input_ready_flag,
  // Mailbox
  input wire logic [35:0] mail1Data,
  input wire logic [35:0] pbMailData_r,
  input wire logic [35:0] mail2Data_r,
  input wire logic        mail2Write_r
);
  logic [35:0] laneMask;
  logic [1:0]  cfgCnt_r;
  logic        cfgOk;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Lane mask follows the pins, which only move during master reset
  assign laneMask = !bus_match_select ? 36'hFFFFFFFFF : size_select ? 36'h1FF : 36'h3FFFF;
  assign cfgOk = (cfgCnt_r == 2'h2) && queue_ab_master_reset_n && queue_ba_master_reset_n;
  // Settle two edges after master reset so the captured set is in force
  always_ff @(posedge clk)
  begin
    if (!rst_n || !queue_ab_master_reset_n || !queue_ba_master_reset_n) cfgCnt_r <= 2'h0;
    else if (cfgCnt_r != 2'h2) cfgCnt_r <= cfgCnt_r + 2'h1;
  end
  // ==========================================================
  // Checks
  // ==========================================================
  a_long_read_pass: assert property (cfgOk && !bus_match_select && abPop |=>
    pbRdData_r == $past(abWord)) else $error("long read not passed whole");
  a_word_lanes: assert property (cfgOk && bus_match_select && !size_select &&
    port_b_output_ready_flag |-> pbRdData_r[35:18] == 18'h0) else $error("word lanes dirty");
  a_byte_lanes: assert property (cfgOk && size_select && bus_match_select &&
    port_b_output_ready_flag |-> pbRdData_r[35:9] == 27'h0) else $error("byte lanes dirty");
  a_mail_out_mask: assert property (cfgOk |=>
    pbMailData_r == ($past(mail1Data) & $past(laneMask))) else $error("mail out mask");
  a_mail_in_mask: assert property (cfgOk && mbSelect && pbWrite |=> mail2Write_r &&
    mail2Data_r == ($past(pbWrData) & $past(laneMask))) else $error("mail in mask");
  a_mail_no_push: assert property (mbSelect && pbWrite |=> !baPush_r)
    else $error("mailbox write reached queue");
  a_push_single: assert property (bus_match_select && baPush_r |=> !baPush_r)
    else $error("narrow push repeated");
  a_long_write_pass: assert property (cfgOk && !bus_match_select && pbWrite && !mbSelect &&
    port_a_input_ready_flag && port_b_input_ready_flag |=> baPush_r &&
    baWord_r == $past(pbWrData)) else $error("long write not committed");
  a_no_ready_reset: assert property (!queue_ba_master_reset_n |-> !port_b_input_ready_flag)
    else $error("input ready during master reset");
  c_byte_push: cover property (baPush_r && bus_match_select && size_select);
  c_long_pop: cover property (abPop && !bus_match_select);
  c_mail_write: cover property (mail2Write_r);
endmodule
bind pbm_port_b_match pbm_port_b_match_properties u_prop (.clk, .rst_n, .bus_match_select,
  .size_select, .queue_ab_master_reset_n, .queue_ba_master_reset_n, .port_a_input_ready_flag,
  .abWord, .abPop, .baWord_r, .baPush_r, .pbWrite, .mbSelect, .pbWrData, .pbRdData_r,
  .port_b_output_ready_flag, .port_b_input_ready_flag, .mail1Data, .pbMailData_r,
  .mail2Data_r, .mail2Write_r);
`default_nettype wire

// file: test/pbm_ab_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbm_ab_ram_model #(
  parameter int CAP = 64
) (
  // Clock
  input  wire logic        clk,
  // Queue RAM sides
  input  wire logic        abPop,
  input  wire logic        baPush_r,
  output logic [35:0]      abWord,
  output logic             abValid,
  output logic             baFull
);
  logic [35:0] mem [0:255];
  logic [35:0] lastWord_r = 36'h0;
  int          head_r = 0;
  int          tail_r = 0;
  int          tailW  = 0;
  int          fill_r = 0;
  // Released head shows the inverse of the last word, never a stale copy
  always @*
  begin
    abValid = (tail_r != head_r);
    abWord  = abValid ? mem[head_r] : ~lastWord_r;
    baFull  = (fill_r >= CAP);
  end
  // Head and tail move by non-blocking update only, so a put or pop never races the design
  always @(posedge clk)
  begin
    tail_r <= tailW;
    if (abPop && abValid)
    begin
      lastWord_r <= mem[head_r];
      head_r     <= head_r + 1;
    end
    if (baPush_r) fill_r <= fill_r + 1;
  end
  // New words stay hidden past the tail until the next clock edge
  task automatic put(input logic [35:0] w);
    mem[tailW] = w;
    tailW++;
  endtask
endmodule
`default_nettype wire

// file: test/pbm_port_b_match_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) cmp(g, e)
module pbm_port_b_match_tb;
  logic clk = 1'b0, rst_n = 1'b0, mrsN = 1'b1, prsN = 1'b1, abPop, abValid, baFull;
  logic bus_match_select = 1'b0, size_select = 1'b0, endian_select = 1'b1;
  logic port_a_input_ready_flag = 1'b1, pbRead = 1'b0, pbWrite = 1'b0, mbSelect = 1'b0;
  logic [35:0] abWord, baWord_r, pbRdData_r, pbMailData_r, mail2Data_r, w, st;
  logic [35:0] pbWrData = 36'h0, mail1Data = 36'h0, expQ[$];
  logic baPush_r, port_b_output_ready_flag, port_b_input_ready_flag, mail2Write_r, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h0053;
  logic wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0, big;
  int n_mismatch = 0, total_checks = 0, n, pw, i;
  // ==========================================================
  // Instances
  // ==========================================================
  pbm_port_b_match dut (.clk, .rst_n, .bus_match_select, .size_select, .endian_select,
    .queue_ab_master_reset_n(mrsN), .queue_ba_master_reset_n(mrsN),
    .queue_ab_partial_reset_n(prsN), .queue_ba_partial_reset_n(prsN),
    .port_a_input_ready_flag, .abWord, .abValid, .abPop, .baFull, .baWord_r, .baPush_r,
    .pbRead, .pbWrite, .mbSelect, .pbWrData, .pbRdData_r, .port_b_output_ready_flag,
    .port_b_input_ready_flag, .mail1Data, .pbMailData_r, .mail2Data_r, .mail2Write_r,
    .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o,
    .wb_ack_o);
  pbm_ab_ram_model u_ram (.clk, .abPop, .baPush_r, .abWord, .abValid, .baFull);
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [35:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed[3:0], seed};
  endfunction
  // Piece k in transfer order; pw of 36 wraps the mask to all ones
  function automatic logic [35:0] piece(input logic [35:0] v, input int k);
    return (v >> (pw * (big ? n - 1 - k : k))) & ((36'h1 << pw) - 36'h1);
  endfunction
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [35:0] g);
    logic [35:0] e;
    e = (expQ.size() != 0) ? expQ.pop_front() : ~g;
    `CHK(g, e);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic waitHi(input logic o);
    int k;
    for (k = 0; k < 40; k++)
    begin
      if ((o ? port_b_output_ready_flag : port_b_input_ready_flag) === 1'b1) break;
      @(posedge clk);
    end
    if (k == 40) n_mismatch++;
  endtask
  // Unused upper lanes carry noise that must be ignored
  task automatic wrw(input logic [35:0] v, input int cnt, input logic mb);
    for (int k = 0; k < cnt; k++)
    begin
      @(posedge clk);
      pbWrite  <= 1'b1;
      mbSelect <= mb;
      pbWrData <= mb ? v : (rnd() << pw) | piece(v, k);
    end
    @(posedge clk);
    pbWrite  <= 1'b0;
    mbSelect <= 1'b0;
  endtask
  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wbx(input logic we, input logic [7:0] a, input logic [35:0] d);
    int k;
    @(posedge clk);
    if (!we) expQ.push_back(d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= we ? d[31:0] : 32'h0;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 20) n_mismatch++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // ==========================================================
  // Clock, watchdog, monitor
  // ==========================================================
  initial forever #5 clk = ~clk;
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  always @(posedge clk) mail1Data <= rnd();
  // Results are taken in the order they were noted
  always @(posedge clk)
  begin
    if (rst_n && baPush_r) chk(baWord_r);
    if (rst_n && mail2Write_r) chk(mail2Data_r);
    if (pbRead && !mbSelect && port_b_output_ready_flag === 1'b1) chk(pbRdData_r);
    if (wb_ack_o === 1'b1 && !wb_we_i) chk({4'h0, wb_dat_o});
  end
  // ==========================================================
  // Main sequence: every width with both orderings
  // ==========================================================
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      n   = (i < 2) ? 1 : (i < 4) ? 2 : 4;
      pw  = 36 / n;
      big = !i[0];
      @(posedge clk);
      mrsN             <= 1'b0;
      bus_match_select <= (i >= 2);
      size_select      <= (i >= 4);
      endian_select    <= big;
      repeat (3) @(posedge clk);
      mrsN <= 1'b1;
      waitHi(1'b0);
      endian_select <= !big;
      st = {32'h0, 1'b1, big, (i >= 4) ? 2'h3 : {1'b0, i >= 2}};
      wbx(1'b0, pbm_pkg::ADDR_STATUS, st | 36'h20);
      // Both holds set: control reads back and input ready drops
      wbx(1'b1, pbm_pkg::ADDR_CTRL, 36'h3);
      wbx(1'b0, pbm_pkg::ADDR_CTRL, 36'h3);
      wbx(1'b0, pbm_pkg::ADDR_STATUS, st);
      wbx(1'b1, pbm_pkg::ADDR_CTRL, 36'h0);
      wbx(1'b1, 8'h0C, {4'h0, seed});
      wbx(1'b0, 8'h0C, 36'h0);
      port_a_input_ready_flag <= 1'b0;
      wrw(rnd(), n, 1'b0);
      port_a_input_ready_flag <= 1'b1;
      if (n > 1)
      begin
        wrw(rnd(), 1, 1'b0);
        prsN <= 1'b0;
        repeat (2) @(posedge clk);
        prsN <= 1'b1;
        waitHi(1'b0);
      end
      w = rnd();
      expQ.push_back(w);
      wrw(w, n, 1'b0);
      repeat (2)
      begin
        w = rnd();
        u_ram.put(w);
        for (int k = 0; k < n; k++) expQ.push_back(piece(w, k));
      end
      waitHi(1'b1);
      @(posedge clk);
      pbRead <= 1'b1;
      repeat (2 * n) @(posedge clk);
      pbRead <= 1'b0;
      w = rnd();
      expQ.push_back(w & ((36'h1 << pw) - 36'h1));
      wrw(w, 1, 1'b1);
      repeat (3) @(posedge clk);
    end
    end_sim();
  end
endmodule
`default_nettype wire
